// *** rtl/ptx_cfg.svh ***
// constants of the transmit stream block: widths, defaults, entry fields, timing
// assumes inclusion by bare name from the package and the ptx_tx_stream module
`ifndef PTX_CFG_SVH
`define PTX_CFG_SVH

// ----------------------------------------
// build defaults
// ----------------------------------------
`define PTX_DATA_W       128
`define PTX_DEPTH        16
`define PTX_RDY_LAT      2
`define PTX_CRD_W        12
`define PTX_CRD_BYTES    16
`define PTX_CRD_RST      12'h000

// ----------------------------------------
// fifo entry fields, payload above them
// ----------------------------------------
`define PTX_F_FIRST      0
`define PTX_F_LAST       1
`define PTX_F_UPPER      2
`define PTX_F_NULL       3
`define PTX_F_PAYLOAD    4

// ----------------------------------------
// timing
// ----------------------------------------
`define PTX_RST_WAIT_CYC 2

`endif

// *** rtl/ptx_pkg.sv ***
// types shared by the transmit stream modules
// assumes ptx_cfg.svh on the include path
`include "ptx_cfg.svh"

package ptx_pkg;

    // ----------------------------------------
    // packet tracker
    // ----------------------------------------
    typedef enum logic [0:0] {
        PKT_IDLE = 1'b0,
        PKT_BODY = 1'b1
    } ptx_pkt_state_t;

    typedef logic [`PTX_CRD_W-1:0] ptx_credit_t;

endpackage

// *** rtl/ptx_mem_if.sv ***
// carrier between the stream controller and its beat memory
// assumes both ends share clk_sys
`timescale 1ns/100ps

interface ptx_mem_if #(
    parameter int EW = 132,
    parameter int AW = 4
);
    logic          wrEn;
    logic [AW-1:0] wrAddr;
    logic [EW-1:0] wrData;
    logic [AW-1:0] rdAddr;
    logic [EW-1:0] rdData;

    modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// *** rtl/ptx_beat_mem.sv ***
// beat memory with a registered read port and write-to-read bypass
// assumes one clock; the read address is the next head pointer
`timescale 1ns/100ps

module ptx_beat_mem #(
    parameter int EW    = 132,
    parameter int DEPTH = 16
) (
    input  wire logic clk_sys,
    ptx_mem_if.mem    port
);
    logic [EW-1:0] memArr [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (port.wrEn) begin
            memArr[port.wrAddr] <= port.wrData;
        end
    end

    // bypass so a beat written into the head slot is visible next cycle
    always_ff @(posedge clk_sys) begin
        if (port.wrEn && (port.wrAddr == port.rdAddr)) begin
            port.rdData <= port.wrData;
        end else begin
            port.rdData <= memArr[port.rdAddr];
        end
    end
endmodule

// *** rtl/ptx_tx_stream.sv ***
// transmit stream front end: accepts beats, throttles with ready, forwards to the link side
// assumes the application keeps its side of the handshake and a same-clock link consumer
`timescale 1ns/100ps
`include "ptx_cfg.svh"

module ptx_tx_stream #(
    parameter int DATA_W  = `PTX_DATA_W,
    parameter int DEPTH   = `PTX_DEPTH,
    parameter int RDY_LAT = `PTX_RDY_LAT
) (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire logic                xmit_beat_valid,
    input  wire logic [DATA_W-1:0]   xmit_beat_payload,
    input  wire logic                xmit_first_beat,
    input  wire logic                xmit_last_beat,
    input  wire logic                xmit_upper_half_unused,
    input  wire logic                xmit_nullify_pkt,
    output logic                     xmit_accept_ready,
    output logic                     txFifoEmpty,
    input  wire logic                crdUpdValid,
    input  wire ptx_pkg::ptx_credit_t crdUpdCplData,
    input  wire ptx_pkg::ptx_credit_t crdUpdNpData,
    input  wire ptx_pkg::ptx_credit_t crdUpdPostData,
    output ptx_pkg::ptx_credit_t     crdLimCplData,
    output ptx_pkg::ptx_credit_t     crdLimNpData,
    output ptx_pkg::ptx_credit_t     crdLimPostData,
    output logic                     linkBeatValid,
    input  wire logic                linkBeatReady,
    output logic [DATA_W-1:0]        linkBeatPayload,
    output logic                     linkFirstBeat,
    output logic                     linkLastBeat,
    output logic                     linkUpperHalfUnused,
    output logic                     linkNullifyPkt
);
    localparam int AW = $clog2(DEPTH);
    localparam int EW = DATA_W + `PTX_F_PAYLOAD;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    // headroom for beats already in flight when ready falls
    localparam logic [AW:0] SLACK_C = (AW+1)'(RDY_LAT + 1);

    // ----------------------------------------
    // build checks
    // ----------------------------------------
    if (!(DATA_W == 64 || DATA_W == 128)) begin : g_bad_width
        $error("data width must be 64 or 128");
    end
    if (RDY_LAT < 1 || RDY_LAT > 2) begin : g_bad_lat
        $error("ready latency must be 1 or 2");
    end
    if (DEPTH < RDY_LAT + 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two above latency plus three");
    end

    function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p, input logic en);
        ptrInc = en ? AW'(p + 1'b1) : p;
    endfunction

    // ----------------------------------------
    // acceptance and occupancy
    // ----------------------------------------
    logic                    ready_q;
    logic [RDY_LAT-1:0]      readyHist_q;
    logic                    readyCycle;
    logic                    push;
    logic                    pop;
    logic [AW:0]             cnt_q;
    logic [AW:0]             cnt_d;
    logic [AW-1:0]           wrPtr_q;
    logic [AW-1:0]           rdPtr_q;
    logic [AW-1:0]           rdPtr_d;
    logic                    linkValid_q;
    logic                    empty_q;

    assign readyCycle = readyHist_q[RDY_LAT-1];
    assign push       = xmit_beat_valid && readyCycle;
    assign pop        = linkValid_q && linkBeatReady;
    assign cnt_d      = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign rdPtr_d    = ptrInc(rdPtr_q, pop);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ready_q     <= 1'b0;
            readyHist_q <= '0;
        end else begin
            // ready falls early enough that in-flight beats still fit
            ready_q     <= (DEPTH_C - cnt_d) > SLACK_C;
            readyHist_q <= RDY_LAT'({readyHist_q, ready_q});
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q       <= '0;
            wrPtr_q     <= '0;
            rdPtr_q     <= '0;
            linkValid_q <= 1'b0;
            empty_q     <= 1'b1;
        end else begin
            cnt_q       <= cnt_d;
            wrPtr_q     <= ptrInc(wrPtr_q, push);
            rdPtr_q     <= rdPtr_d;
            linkValid_q <= cnt_d != '0;
            empty_q     <= cnt_d == '0;
        end
    end

    // ----------------------------------------
    // packet tracking and nullify
    // ----------------------------------------
    ptx_pkg::ptx_pkt_state_t pktState_q;
    logic                    errSeen_q;
    logic                    upperBit;

    // err at first or last beat is ignored: it must fall strictly inside
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pktState_q <= ptx_pkg::PKT_IDLE;
            errSeen_q  <= 1'b0;
        end else if (push) begin
            case (pktState_q)
                ptx_pkg::PKT_IDLE: begin
                    if (xmit_first_beat && !xmit_last_beat) begin
                        pktState_q <= ptx_pkg::PKT_BODY;
                    end
                    errSeen_q <= 1'b0;
                end
                ptx_pkg::PKT_BODY: begin
                    if (xmit_last_beat) begin
                        pktState_q <= ptx_pkg::PKT_IDLE;
                        errSeen_q  <= 1'b0;
                    end else if (xmit_nullify_pkt) begin
                        errSeen_q <= 1'b1;
                    end
                end
                default: begin
                    pktState_q <= ptx_pkg::PKT_IDLE;
                    errSeen_q  <= 1'b0;
                end
            endcase
        end
    end

    // empty qualifier only kept on a last beat of a 128-bit bus
    assign upperBit = (DATA_W == 128) && xmit_last_beat && xmit_upper_half_unused;

    // ----------------------------------------
    // beat memory
    // ----------------------------------------
    ptx_mem_if #(.EW(EW), .AW(AW)) memPort ();

    always_comb begin
        memPort.wrEn   = push;
        memPort.wrAddr = wrPtr_q;
        memPort.rdAddr = rdPtr_d;
        memPort.wrData = '0;
        memPort.wrData[`PTX_F_FIRST] = xmit_first_beat;
        memPort.wrData[`PTX_F_LAST]  = xmit_last_beat;
        memPort.wrData[`PTX_F_UPPER] = upperBit;
        memPort.wrData[`PTX_F_NULL]  = xmit_last_beat && errSeen_q && (pktState_q == ptx_pkg::PKT_BODY);
        memPort.wrData[EW-1:`PTX_F_PAYLOAD] = xmit_beat_payload;
    end

    ptx_beat_mem #(.EW(EW), .DEPTH(DEPTH)) u_mem (
        .clk_sys (clk_sys),
        .port    (memPort)
    );

    // ----------------------------------------
    // credit limits
    // ----------------------------------------
    ptx_pkg::ptx_credit_t crdCpl_q;
    ptx_pkg::ptx_credit_t crdNp_q;
    ptx_pkg::ptx_credit_t crdPost_q;

    // units of 16 payload bytes; held between updates
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            crdCpl_q  <= `PTX_CRD_RST;
            crdNp_q   <= `PTX_CRD_RST;
            crdPost_q <= `PTX_CRD_RST;
        end else if (crdUpdValid) begin
            crdCpl_q  <= crdUpdCplData;
            crdNp_q   <= crdUpdNpData;
            crdPost_q <= crdUpdPostData;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign xmit_accept_ready   = ready_q;
    assign txFifoEmpty         = empty_q;
    assign crdLimCplData       = crdCpl_q;
    assign crdLimNpData        = crdNp_q;
    assign crdLimPostData      = crdPost_q;
    assign linkBeatValid       = linkValid_q;
    assign linkBeatPayload     = memPort.rdData[EW-1:`PTX_F_PAYLOAD];
    assign linkFirstBeat       = memPort.rdData[`PTX_F_FIRST];
    assign linkLastBeat        = memPort.rdData[`PTX_F_LAST];
    assign linkUpperHalfUnused = memPort.rdData[`PTX_F_UPPER];
    assign linkNullifyPkt      = memPort.rdData[`PTX_F_NULL];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_no_take_unready;
        @(posedge clk_sys) disable iff (!arst_n)
        (!readyCycle && !pop) |=> (cnt_q == $past(cnt_q));
    endproperty
    a_no_take_unready: assert property (p_no_take_unready) else $error("beat taken outside a ready cycle");

    property p_ready_cycle;
        @(posedge clk_sys) disable iff (!arst_n)
        ready_q ##RDY_LAT (xmit_beat_valid && !pop) |=> (cnt_q == $past(cnt_q) + 1'b1);
    endproperty
    a_ready_cycle: assert property (p_ready_cycle) else $error("valid in ready cycle not taken");

    property p_empty_flag;
        @(posedge clk_sys) disable iff (!arst_n)
        txFifoEmpty == ((wrPtr_q == rdPtr_q) && !cnt_q[AW]);
    endproperty
    a_empty_flag: assert property (p_empty_flag) else $error("fifo empty flag wrong");

    property p_upper_only_last;
        @(posedge clk_sys) disable iff (!arst_n)
        (linkBeatValid && linkUpperHalfUnused) |-> (linkLastBeat && DATA_W == 128);
    endproperty
    a_upper_only_last: assert property (p_upper_only_last) else $error("empty qualifier off last beat");

    property p_crd_cpl;
        @(posedge clk_sys) disable iff (!arst_n)
        crdUpdValid |=> (crdLimCplData == $past(crdUpdCplData));
    endproperty
    a_crd_cpl: assert property (p_crd_cpl) else $error("completion credit not loaded");

    property p_crd_np;
        @(posedge clk_sys) disable iff (!arst_n)
        crdUpdValid |=> (crdLimNpData == $past(crdUpdNpData));
    endproperty
    a_crd_np: assert property (p_crd_np) else $error("non-posted credit not loaded");

    property p_crd_post;
        @(posedge clk_sys) disable iff (!arst_n)
        crdUpdValid |=> (crdLimPostData == $past(crdUpdPostData));
    endproperty
    a_crd_post: assert property (p_crd_post) else $error("posted credit not loaded");

    property p_crd_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        !crdUpdValid |=> ($stable(crdLimCplData) && $stable(crdLimNpData) && $stable(crdLimPostData));
    endproperty
    a_crd_hold: assert property (p_crd_hold) else $error("credit limit moved without update");

    property p_no_overflow;
        @(posedge clk_sys) disable iff (!arst_n)
        (cnt_q <= DEPTH_C) && (!xmit_accept_ready || (DEPTH_C - cnt_q) > 1);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("beat memory overflow");
endmodule

// *** sim/ptx_app_model.sv ***
// application-side packet source for the transmit stream
// assumes ready latency 2 and the core clock
`timescale 1ns/100ps

module ptx_app_model #(
    parameter int DATA_W = 128
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic         xmit_accept_ready,
    input  wire logic         cmdGo,
    input  wire logic [7:0]   cmdTag,
    input  wire logic [7:0]   cmdLen,
    input  wire logic [7:0]   cmdNullAt,
    input  wire logic         cmdUpper,
    output logic              busy,
    output logic              xmit_beat_valid,
    output logic [DATA_W-1:0] xmit_beat_payload,
    output logic              xmit_first_beat,
    output logic              xmit_last_beat,
    output logic              xmit_upper_half_unused,
    output logic              xmit_nullify_pkt
);
    logic       rdy1Q;
    logic       rdy2Q;
    logic       goQ;
    logic       active;
    logic [7:0] idx;

    // ----
    // ready and start registered
    // ----
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdy1Q <= 1'h0;
            rdy2Q <= 1'h0;
            goQ   <= 1'h0;
        end else begin
            rdy1Q <= xmit_accept_ready;
            rdy2Q <= rdy1Q;
            goQ   <= cmdGo;
        end
    end

    initial begin
        active = 1'h0;
        idx = 8'h00;
        xmit_beat_valid = 1'h0;
        xmit_beat_payload = '0;
        xmit_first_beat = 1'h0;
        xmit_last_beat = 1'h0;
        xmit_upper_half_unused = 1'h0;
        xmit_nullify_pkt = 1'h0;
    end

    // ----
    // beats only in ready cycles; idle data inverted each cycle, so it equals the last beat again after every second idle cycle
    // ----
    always @(negedge clk_sys) begin
        if (goQ && !active) begin
            active = 1'h1;
            idx = 8'h00;
        end
        if (active && rdy2Q) begin
            xmit_beat_valid <= 1'h1;
            xmit_beat_payload <= {(DATA_W/16){cmdTag, idx}};
            xmit_first_beat <= (idx == 8'h00);
            xmit_last_beat <= (idx == cmdLen - 8'h01);
            xmit_upper_half_unused <= cmdUpper;
            xmit_nullify_pkt <= (cmdNullAt != 8'h00) && (idx == cmdNullAt);
            idx = idx + 8'h01;
            active = (idx != cmdLen);
        end else begin
            xmit_beat_valid <= 1'h0;
            xmit_first_beat <= 1'h0;
            xmit_last_beat <= 1'h0;
            xmit_nullify_pkt <= 1'h0;
            xmit_beat_payload <= ~xmit_beat_payload;
        end
    end

    assign busy = active | goQ;
endmodule

// *** sim/testbench.sv ***
// self-checking bench of the transmit stream front end
// assumes the application model and the default build
`timescale 1ns/100ps

module testbench;
    logic                 clk_sys, arst_n, busy, cmdGo, cmdUpper;
    logic [7:0]           cmdTag, cmdLen, cmdNullAt;
    logic                 aValid, aFirst, aLast, aUpper, aNull, ready, txFifoEmpty;
    logic [127:0]         aData, linkBeatPayload;
    logic                 crdUpdValid, linkBeatValid, linkBeatReady;
    logic                 linkFirstBeat, linkLastBeat, linkUpperHalfUnused, linkNullifyPkt;
    ptx_pkg::ptx_credit_t updCpl, updNp, updPost, limCpl, limNp, limPost;
    logic [19:0]          rxQ[$];
    int                   num_errors, num_checks;

    ptx_app_model app_u (.clk_sys(clk_sys), .arst_n(arst_n), .xmit_accept_ready(ready), .cmdGo(cmdGo),
        .cmdTag(cmdTag), .cmdLen(cmdLen), .cmdNullAt(cmdNullAt), .cmdUpper(cmdUpper), .busy(busy),
        .xmit_beat_valid(aValid), .xmit_beat_payload(aData), .xmit_first_beat(aFirst),
        .xmit_last_beat(aLast), .xmit_upper_half_unused(aUpper), .xmit_nullify_pkt(aNull));

    ptx_tx_stream dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .xmit_beat_valid(aValid),
        .xmit_beat_payload(aData), .xmit_first_beat(aFirst), .xmit_last_beat(aLast),
        .xmit_upper_half_unused(aUpper), .xmit_nullify_pkt(aNull), .xmit_accept_ready(ready),
        .txFifoEmpty(txFifoEmpty), .crdUpdValid(crdUpdValid), .crdUpdCplData(updCpl),
        .crdUpdNpData(updNp), .crdUpdPostData(updPost), .crdLimCplData(limCpl), .crdLimNpData(limNp),
        .crdLimPostData(limPost), .linkBeatValid(linkBeatValid), .linkBeatReady(linkBeatReady),
        .linkBeatPayload(linkBeatPayload), .linkFirstBeat(linkFirstBeat), .linkLastBeat(linkLastBeat),
        .linkUpperHalfUnused(linkUpperHalfUnused), .linkNullifyPkt(linkNullifyPkt));

    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ----
    // link side monitor
    // ----
    always @(posedge clk_sys) begin
        if (linkBeatValid === 1'h1 && linkBeatReady === 1'h1) begin
            rxQ.push_back({linkNullifyPkt, linkUpperHalfUnused, linkLastBeat, linkFirstBeat, linkBeatPayload[15:0]});
        end
    end

    task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic launch(input logic [7:0] tag, len, nul, input logic up);
        @(negedge clk_sys);
        cmdTag = tag;
        cmdLen = len;
        cmdNullAt = nul;
        cmdUpper = up;
        cmdGo = 1'h1;
        @(negedge clk_sys);
        cmdGo = 1'h0;
    endtask

    // every beat in order; first flag on beat 0 only, other flags only on the last beat
    task automatic expectPkt(input logic [7:0] tag, len, nul, input logic up);
        logic l;
        for (int n = 0; n < 400 && (rxQ.size() < len || busy); n++) @(negedge clk_sys);
        if (rxQ.size() < len) begin
            check("beat count", 20'(len), 20'(rxQ.size()));
            conclude();
        end
        for (int i = 0; i < len; i++) begin
            l = (i == len - 1);
            check("link beat", {nul != 8'h00 && l, up && l, l, i == 0, tag, i[7:0]}, rxQ.pop_front());
        end
        repeat (3) @(negedge clk_sys);
        check("fifo empty", 20'h1, {19'h0, txFifoEmpty});
    endtask

    task automatic scReset();
        check("fifo empty", 20'h1, {19'h0, txFifoEmpty});
        check("ready", 20'h1, {19'h0, ready});
        check("credit limits", 20'h0, {8'h0, limCpl | limNp | limPost});
    endtask

    task automatic scCredits();
        crdUpdValid = 1'h1;
        updCpl = 12'habc;
        updNp = 12'h123;
        updPost = 12'hfff;
        @(negedge clk_sys);
        crdUpdValid = 1'h0;
        updCpl = 12'h555;
        updNp = 12'h555;
        updPost = 12'h555;
        check("completion limit", 20'habc, {8'h0, limCpl});
        check("non-posted limit", 20'h123, {8'h0, limNp});
        repeat (3) @(negedge clk_sys);
        check("posted limit held", 20'hfff, {8'h0, limPost});
        check("completion limit held", 20'habc, {8'h0, limCpl});
    endtask

    // upper flag sent on every beat, only the last one may carry it
    task automatic scBasic();
        launch(8'h11, 8'h03, 8'h00, 1'h1);
        expectPkt(8'h11, 8'h03, 8'h00, 1'h1);
        launch(8'h22, 8'h01, 8'h00, 1'h1);
        expectPkt(8'h22, 8'h01, 8'h00, 1'h1);
    endtask

    // link stalls: ready must fall, no beat lost while source holds off
    task automatic scStall();
        linkBeatReady = 1'h0;
        launch(8'h33, 8'h14, 8'h00, 1'h0);
        repeat (40) @(negedge clk_sys);
        check("ready under stall", 20'h0, {19'h0, ready});
        check("fifo empty under stall", 20'h0, {19'h0, txFifoEmpty});
        linkBeatReady = 1'h1;
        expectPkt(8'h33, 8'h14, 8'h00, 1'h0);
    endtask

    task automatic scNullify();
        launch(8'h44, 8'h04, 8'h02, 1'h0);
        expectPkt(8'h44, 8'h04, 8'h02, 1'h0);
        launch(8'h55, 8'h02, 8'h00, 1'h0);
        expectPkt(8'h55, 8'h02, 8'h00, 1'h0);
    endtask

    initial begin
        num_errors = 0;
        num_checks = 0;
        arst_n = 1'h0;
        cmdGo = 1'h0;
        cmdTag = 8'h00;
        cmdLen = 8'h01;
        cmdNullAt = 8'h00;
        cmdUpper = 1'h0;
        crdUpdValid = 1'h0;
        updCpl = 12'h000;
        updNp = 12'h000;
        updPost = 12'h000;
        linkBeatReady = 1'h1;
        repeat (16) @(negedge clk_sys);
        arst_n = 1'h1;
        repeat (3) @(negedge clk_sys);
        scReset();
        scCredits();
        scBasic();
        scStall();
        scNullify();
        conclude();
    end
endmodule
